// ### logic/bsw_swapper.sv
// How it works
// R01 - Storage keeps big-endian order; storage side is never reordered
// R02 - Cache block transfer addresses pass to storage unchanged in both modes
// R03 - Processor-to-storage data passes straight, no lane swap
// R04 - Little-endian: I/O master storage addresses are modified before access
// R05 - Same modification for transportable and presentation adaptors
// R06 - Little-endian: I/O-storage data reversed within each doubleword
// R07 - Narrow or unaligned transfers: each byte goes to mirrored lane
// R08 - One-word I/O bus: even/odd words land in mirrored storage halves
// R09 - Doubleword-crossing accesses are refused, must be split into several
// R10 - Requester splits unaligned accesses into aligned byte/half/word pieces
// R11 - Little-endian: processor I/O addresses are modified a second time
// R12 - Re-modification applies to I/O memory and control registers alike
// R13 - Processor-to-I/O data lane-swapped as on I/O-to-storage path
// R14 - Little-endian: every processor-to-I/O transfer is lane reversed
// R15 - Any enabled byte subset within a doubleword is swapped correctly
// R16 - I/O peer-to-peer transfers bypass modification and reversal
// R17 - All I/O storage accesses go through mode-controlled swap and modify
// R18 - Firmware sets endian mode before handing over to the system
// R19 - Big-endian: no swap, no modify; little-endian: both
// R20 - Little-endian lane n maps to lane 7-n; big-endian n to n
// R21 - One-word bus little-endian: even word to lanes 7-4, odd to 3-0
// R22 - Mode control is writable and readable in both modes
// R23 - Modification xors low bits: 111 byte, 110 half, 100 word, 000 dword
`timescale 1ns/100ps
`default_nettype none
module bsw_swapper (
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    // Mode control
    input  wire logic                       mode_wr_i,
    input  wire logic                       mode_wdata_i,
    output logic                            mode_o,
    // Processor request
    input  wire logic                       cpu_valid_i,
    input  wire logic                       cpu_write_i,
    input  wire logic                       cpu_to_io_i,
    input  wire logic                       cpu_cache_i,
    input  wire bsw_pkg::bsw_size_t         cpu_size_i,
    input  wire logic [bsw_pkg::ADDR_W-1:0] cpu_addr_i,
    input  wire logic [bsw_pkg::DATA_W-1:0] cpu_wdata_i,
    input  wire logic [bsw_pkg::LANES-1:0]  cpu_be_i,
    // Processor to storage
    output logic                            sto_valid_o,
    output logic                            sto_write_o,
    output logic                            sto_cache_o,
    output logic [bsw_pkg::ADDR_W-1:0]      sto_addr_o,
    output logic [bsw_pkg::DATA_W-1:0]      sto_wdata_o,
    output logic [bsw_pkg::LANES-1:0]       sto_be_o,
    // Processor to I/O
    output logic                            pio_valid_o,
    output logic                            pio_write_o,
    output logic [bsw_pkg::ADDR_W-1:0]      pio_addr_o,
    output logic [bsw_pkg::DATA_W-1:0]      pio_wdata_o,
    output logic [bsw_pkg::LANES-1:0]       pio_be_o,
    // Read returns toward the processor, and toward the I/O master when sto_rdma_i is set
    input  wire logic                       sto_rvalid_i,
    input  wire logic                       sto_rdma_i,
    input  wire logic [bsw_pkg::DATA_W-1:0] sto_rdata_i,
    input  wire logic                       pio_rvalid_i,
    input  wire logic [bsw_pkg::DATA_W-1:0] pio_rdata_i,
    output logic                            cpu_rvalid_o,
    output logic [bsw_pkg::DATA_W-1:0]      cpu_rdata_o,
    // I/O master request
    input  wire logic                       dma_valid_i,
    input  wire logic                       dma_write_i,
    input  wire logic                       dma_peer_i,
    input  wire logic                       dma_narrow_i,
    input  wire bsw_pkg::bsw_size_t         dma_size_i,
    input  wire logic [bsw_pkg::ADDR_W-1:0] dma_addr_i,
    input  wire logic [bsw_pkg::DATA_W-1:0] dma_wdata_i,
    input  wire logic [bsw_pkg::LANES-1:0]  dma_be_i,
    // I/O master to storage
    output logic                            dsto_valid_o,
    output logic                            dsto_write_o,
    output logic [bsw_pkg::ADDR_W-1:0]      dsto_addr_o,
    output logic [bsw_pkg::DATA_W-1:0]      dsto_wdata_o,
    output logic [bsw_pkg::LANES-1:0]       dsto_be_o,
    // I/O peer bypass
    output logic                            peer_valid_o,
    output logic                            peer_write_o,
    output logic [bsw_pkg::ADDR_W-1:0]      peer_addr_o,
    output logic [bsw_pkg::DATA_W-1:0]      peer_wdata_o,
    output logic [bsw_pkg::LANES-1:0]       peer_be_o,
    // I/O master status and read data
    output logic                            dma_split_err_o,
    output logic                            dma_rvalid_o,
    output logic [bsw_pkg::DATA_W-1:0]      dma_rdata_o
);
    import bsw_pkg::*;

    // Mirror byte lanes within a doubleword; its own inverse
    function automatic logic [DATA_W-1:0] rev_data(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < LANES; i++) begin
            r[i*BYTE_W +: BYTE_W] = d[(LANES-1-i)*BYTE_W +: BYTE_W]; // R20
        end
        return r;
    endfunction : rev_data

    // Mirror per-lane enables, so odd byte subsets follow their data
    function automatic logic [LANES-1:0] rev_be(input logic [LANES-1:0] b);
        logic [LANES-1:0] r;
        r = '0;
        for (int i = 0; i < LANES; i++) begin
            r[i] = b[LANES-1-i]; // R15
        end
        return r;
    endfunction : rev_be

    // Low-bit modification by access size, little-endian only
    function automatic logic [ADDR_W-1:0] mod_addr(input logic [ADDR_W-1:0] a,
                                                   input bsw_size_t s,
                                                   input logic le);
        logic [2:0] x;
        case (s)
            BSW_SZ_BYTE: x = BSW_MOD_BYTE; // R23
            BSW_SZ_HALF: x = BSW_MOD_HALF; // R23
            BSW_SZ_WORD: x = BSW_MOD_WORD; // R23
            default:     x = BSW_MOD_DWORD; // R23
        endcase
        if (le != BSW_MODE_LE) begin
            x = BSW_MOD_DWORD; // R19
        end
        return {a[ADDR_W-1:LOW_W], a[LOW_W-1:0] ^ x};
    endfunction : mod_addr

    logic                mode_reg;
    logic                dma_le_c;
    logic                odd_c;
    logic [3:0]          nbytes_c;
    logic [3:0]          end_c;
    logic                dma_err_c;
    logic                dma_go_c;
    logic [DATA_W-1:0]   dma_wide_c;
    logic [LANES-1:0]    dma_wbe_c;
    logic                rd_narrow_reg;
    logic                rd_odd_reg;
    logic [DATA_W-1:0]   srd_swap_c;

    // Mode control: firmware stores it once at boot, readable any time
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_reg <= BSW_MODE_RST;
        end else if (mode_wr_i) begin
            mode_reg <= mode_wdata_i; // R22 R18
        end
    end
    assign mode_o = mode_reg;
    assign dma_le_c = (mode_reg == BSW_MODE_LE);

    // Crossing check; address modification is meaningless on such accesses
    assign nbytes_c  = BSW_ONE_BYTE << dma_size_i;
    assign end_c     = {1'b0, dma_addr_i[LOW_W-1:0]} + nbytes_c;
    assign odd_c     = dma_addr_i[LOW_W-1];
    assign dma_err_c = (end_c > BSW_DW_BYTES)
                     || (dma_le_c && ((dma_addr_i[LOW_W-1:0] & (nbytes_c[2:0] - BSW_LOW_ONE)) != BSW_LOW_ZERO)); // R09 R10
    assign dma_go_c  = dma_valid_i && !dma_peer_i && !dma_err_c;

    // Widen one-word bus data into its doubleword half before any swap
    always_comb begin
        dma_wide_c = dma_wdata_i;
        dma_wbe_c  = dma_be_i;
        if (dma_narrow_i) begin
            if (odd_c) begin
                dma_wide_c = {{WORD_W{1'b0}}, dma_wdata_i[WORD_W-1:0]}; // R08
                dma_wbe_c  = {{WORD_LANES{1'b0}}, dma_be_i[WORD_LANES-1:0]};
            end else begin
                dma_wide_c = {dma_wdata_i[WORD_W-1:0], {WORD_W{1'b0}}}; // R08
                dma_wbe_c  = {dma_be_i[WORD_LANES-1:0], {WORD_LANES{1'b0}}};
            end
        end
    end

    // Processor to storage: always straight through, storage stays big-endian
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sto_valid_o <= 1'b0;
            sto_write_o <= 1'b0;
            sto_cache_o <= 1'b0;
            sto_addr_o  <= '0;
            sto_wdata_o <= '0;
            sto_be_o    <= '0;
        end else begin
            sto_valid_o <= cpu_valid_i && !cpu_to_io_i;
            sto_write_o <= cpu_write_i;
            sto_cache_o <= cpu_cache_i;
            sto_addr_o  <= cpu_addr_i;  // R02
            sto_wdata_o <= cpu_wdata_i; // R03 R01
            sto_be_o    <= cpu_be_i;    // R03
        end
    end

    // Processor to I/O: second modification plus lane reversal in LE
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pio_valid_o <= 1'b0;
            pio_write_o <= 1'b0;
            pio_addr_o  <= '0;
            pio_wdata_o <= '0;
            pio_be_o    <= '0;
        end else begin
            pio_valid_o <= cpu_valid_i && cpu_to_io_i;
            pio_write_o <= cpu_write_i;
            pio_addr_o  <= mod_addr(cpu_addr_i, cpu_size_i, mode_reg); // R11 R12
            pio_wdata_o <= dma_le_c ? rev_data(cpu_wdata_i) : cpu_wdata_i; // R13 R14
            pio_be_o    <= dma_le_c ? rev_be(cpu_be_i) : cpu_be_i; // R15
        end
    end

    // I/O master to storage: every access crosses the swap and modify stage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dsto_valid_o    <= 1'b0;
            dsto_write_o    <= 1'b0;
            dsto_addr_o     <= '0;
            dsto_wdata_o    <= '0;
            dsto_be_o       <= '0;
            dma_split_err_o <= 1'b0;
        end else begin
            dsto_valid_o    <= dma_go_c;
            dsto_write_o    <= dma_write_i;
            dsto_addr_o     <= mod_addr(dma_addr_i, dma_size_i, mode_reg); // R04 R05 R17
            dsto_wdata_o    <= dma_le_c ? rev_data(dma_wide_c) : dma_wide_c; // R06 R07 R21
            dsto_be_o       <= dma_le_c ? rev_be(dma_wbe_c) : dma_wbe_c; // R07
            dma_split_err_o <= dma_valid_i && !dma_peer_i && dma_err_c; // R09
        end
    end

    // Peer transfers never see the endian logic
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            peer_valid_o <= 1'b0;
            peer_write_o <= 1'b0;
            peer_addr_o  <= '0;
            peer_wdata_o <= '0;
            peer_be_o    <= '0;
        end else begin
            peer_valid_o <= dma_valid_i && dma_peer_i; // R16
            peer_write_o <= dma_write_i;
            peer_addr_o  <= dma_addr_i;  // R16
            peer_wdata_o <= dma_wdata_i; // R16
            peer_be_o    <= dma_be_i;
        end
    end

    // Word selection of the last I/O read; one read outstanding at a time
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_narrow_reg <= 1'b0;
            rd_odd_reg    <= 1'b0;
        end else if (dma_go_c && !dma_write_i) begin
            rd_narrow_reg <= dma_narrow_i;
            rd_odd_reg    <= odd_c;
        end
    end

    // Storage read toward I/O: reverse, then pick the word half
    assign srd_swap_c = dma_le_c ? rev_data(sto_rdata_i) : sto_rdata_i; // R06
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dma_rvalid_o <= 1'b0;
            dma_rdata_o  <= '0;
        end else begin
            dma_rvalid_o <= sto_rvalid_i && sto_rdma_i;
            if (!rd_narrow_reg) begin
                dma_rdata_o <= srd_swap_c;
            end else if (rd_odd_reg) begin
                dma_rdata_o <= {{WORD_W{1'b0}}, srd_swap_c[WORD_W-1:0]}; // R08
            end else begin
                dma_rdata_o <= {{WORD_W{1'b0}}, srd_swap_c[DATA_W-1:WORD_W]}; // R08
            end
        end
    end

    // Read data to the processor; I/O return wins a same-cycle clash
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cpu_rvalid_o <= 1'b0;
            cpu_rdata_o  <= '0;
        end else begin
            cpu_rvalid_o <= pio_rvalid_i || (sto_rvalid_i && !sto_rdma_i);
            if (pio_rvalid_i) begin
                cpu_rdata_o <= dma_le_c ? rev_data(pio_rdata_i) : pio_rdata_i; // R13
            end else begin
                cpu_rdata_o <= sto_rdata_i; // R03
            end
        end
    end

    // Checks next to the logic they guard
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_sto_addr_pass: assert property (sto_valid_o |-> sto_addr_o == $past(cpu_addr_i)) // R02
        else $error("storage address altered");
    a_sto_data_pass: assert property (sto_valid_o |-> sto_wdata_o == $past(cpu_wdata_i)) // R03
        else $error("storage data altered");
    a_dma_byte_mod: assert property ($past(dma_go_c && dma_le_c && dma_size_i == BSW_SZ_BYTE) // R04
        |-> dsto_addr_o[2:0] == ~$past(dma_addr_i[2:0]))
        else $error("byte address not modified");
    a_dma_word_mod: assert property ($past(dma_go_c && dma_le_c && dma_size_i == BSW_SZ_WORD) // R23
        |-> dsto_addr_o[2:0] == ($past(dma_addr_i[2:0]) ^ BSW_MOD_WORD))
        else $error("word address not modified");
    a_dma_lane_rev: assert property ($past(dma_go_c && dma_le_c && !dma_narrow_i) // R20
        |-> dsto_wdata_o[7:0] == $past(dma_wdata_i[63:56]))
        else $error("lane 0 not moved to lane 7");
    a_dma_be_plain: assert property ($past(dma_go_c && !dma_le_c && !dma_narrow_i) // R19
        |-> dsto_wdata_o == $past(dma_wdata_i) && dsto_addr_o == $past(dma_addr_i))
        else $error("big-endian path altered");
    a_narrow_odd_le: assert property ($past(dma_go_c && dma_le_c && dma_narrow_i && odd_c) // R21
        |-> dsto_wdata_o[39:32] == $past(dma_wdata_i[31:24]))
        else $error("odd word byte 0 not in lane 3");
    a_peer_bypass: assert property (peer_valid_o // R16
        |-> peer_addr_o == $past(dma_addr_i) && peer_wdata_o == $past(dma_wdata_i) && !dsto_valid_o)
        else $error("peer transfer altered");
    a_pio_word_mod: assert property ($past(cpu_valid_i && cpu_to_io_i && dma_le_c && cpu_size_i == BSW_SZ_WORD) // R11
        |-> pio_addr_o[2:0] == ($past(cpu_addr_i[2:0]) ^ BSW_MOD_WORD))
        else $error("I/O address not re-modified");
    a_pio_be_rev: assert property ($past(cpu_valid_i && cpu_to_io_i && dma_le_c) // R14
        |-> pio_be_o[0] == $past(cpu_be_i[7]) && pio_be_o[7] == $past(cpu_be_i[0])
            && pio_wdata_o[63:56] == $past(cpu_wdata_i[7:0]))
        else $error("I/O lanes not reversed");
    a_split_refuse: assert property ($past(dma_valid_i && !dma_peer_i && end_c > BSW_DW_BYTES) // R09
        |-> dma_split_err_o && !dsto_valid_o)
        else $error("crossing access not refused");
    a_mode_hold: assert property (!$past(mode_wr_i) |-> $stable(mode_o)) // R22
        else $error("mode changed without a store");

    c_le_dma_write: cover property (dsto_valid_o && dsto_write_o && mode_o == BSW_MODE_LE);
    c_narrow_odd:   cover property (dma_go_c && dma_narrow_i && odd_c && dma_le_c);
    c_peer:         cover property (peer_valid_o);
    c_pio_le:       cover property (pio_valid_o && mode_o == BSW_MODE_LE);
    c_split:        cover property (dma_split_err_o);
endmodule : bsw_swapper
`default_nettype wire

// ### logic/bsw_pkg.sv
`default_nettype none
package bsw_pkg;
    // Bus geometry
    localparam int DATA_W     = 64;
    localparam int ADDR_W     = 32;
    localparam int WORD_W     = 32;
    localparam int BYTE_W     = 8;
    localparam int LANES      = 8;
    localparam int WORD_LANES = 4;
    localparam int LOW_W      = 3;

    // Transfer sizes, in log2 of bytes
    typedef enum logic [1:0] {
        BSW_SZ_BYTE  = 2'h0,
        BSW_SZ_HALF  = 2'h1,
        BSW_SZ_WORD  = 2'h2,
        BSW_SZ_DWORD = 2'h3
    } bsw_size_t;

    // Low address bits flipped in little-endian mode
    localparam logic [2:0] BSW_MOD_BYTE  = 3'h7;
    localparam logic [2:0] BSW_MOD_HALF  = 3'h6;
    localparam logic [2:0] BSW_MOD_WORD  = 3'h4;
    localparam logic [2:0] BSW_MOD_DWORD = 3'h0;

    // Endian mode encoding and reset value
    localparam logic BSW_MODE_BE  = 1'b0;
    localparam logic BSW_MODE_LE  = 1'b1;
    localparam logic BSW_MODE_RST = BSW_MODE_BE;

    // Doubleword size in bytes, one-byte unit
    localparam logic [3:0] BSW_DW_BYTES = 4'h8;
    localparam logic [3:0] BSW_ONE_BYTE = 4'h1;
    localparam logic [2:0] BSW_LOW_ONE  = 3'h1;
    localparam logic [2:0] BSW_LOW_ZERO = 3'h0;
endpackage : bsw_pkg
`default_nettype wire

// ### testbench/bsw_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module bsw_far_side (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [3:0]  lat_i,
    input  wire logic        sto_rd_i,
    input  wire logic        dma_rd_i,
    input  wire logic        pio_rd_i,
    input  wire logic [31:0] addr_i,
    output logic             sto_rvalid_o,
    output logic             sto_rdma_o,
    output logic [63:0]      sto_rdata_o,
    output logic             pio_rvalid_o,
    output logic [63:0]      pio_rdata_o
);
    logic [3:0]  cnt_reg;
    logic        busy_reg;
    logic [1:0]  kind_reg;
    logic [31:0] addr_reg;

    // One read in flight, answered after lat_i idle cycles with address-tied data
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg      <= 4'h0;
            busy_reg     <= 1'b0;
            kind_reg     <= 2'h0;
            addr_reg     <= 32'h0;
            sto_rvalid_o <= 1'b0;
            sto_rdma_o   <= 1'b0;
            sto_rdata_o  <= 64'h0;
            pio_rvalid_o <= 1'b0;
            pio_rdata_o  <= 64'h0;
        end else begin
            sto_rvalid_o <= 1'b0;
            pio_rvalid_o <= 1'b0;
            // Released data toggles so stale values never look valid
            sto_rdata_o  <= ~sto_rdata_o;
            pio_rdata_o  <= ~pio_rdata_o;
            if (sto_rd_i || dma_rd_i || pio_rd_i) begin
                busy_reg <= 1'b1;
                cnt_reg  <= lat_i;
                kind_reg <= {pio_rd_i, dma_rd_i};
                addr_reg <= addr_i;
            end else if (busy_reg && cnt_reg != 4'h0) begin
                cnt_reg <= cnt_reg - 4'h1;
            end else if (busy_reg) begin
                busy_reg <= 1'b0;
                if (kind_reg[1]) begin
                    pio_rvalid_o <= 1'b1;
                    pio_rdata_o  <= {addr_reg, ~addr_reg};
                end else begin
                    sto_rvalid_o <= 1'b1;
                    sto_rdma_o   <= kind_reg[0];
                    sto_rdata_o  <= {addr_reg, ~addr_reg};
                end
            end
        end
    end
endmodule : bsw_far_side
`default_nettype wire

// ### testbench/tb_bi_endian_io_storage_swapper.sv
`timescale 1ns/100ps
`default_nettype none
module tb_bi_endian_io_storage_swapper;
    import bsw_pkg::*;
    logic        clk_i, reset_n_i, mode_wr_i, mode_wdata_i, mode_o, cpu_valid_i, cpu_write_i, cpu_to_io_i;
    logic        cpu_cache_i, sto_valid_o, sto_write_o, sto_cache_o, pio_valid_o, pio_write_o, sto_rvalid_i;
    logic        sto_rdma_i, pio_rvalid_i, cpu_rvalid_o, dma_valid_i, dma_write_i, dma_peer_i, dma_narrow_i;
    logic        dsto_valid_o, dsto_write_o, peer_valid_o, peer_write_o, dma_split_err_o, dma_rvalid_o, le;
    bsw_size_t   cpu_size_i, dma_size_i, sz;
    logic [31:0] cpu_addr_i, sto_addr_o, pio_addr_o, dma_addr_i, dsto_addr_o, peer_addr_o, a, ea;
    logic [63:0] cpu_wdata_i, sto_wdata_o, pio_wdata_o, sto_rdata_i, pio_rdata_i, cpu_rdata_o, d;
    logic [63:0] dma_wdata_i, dsto_wdata_o, peer_wdata_o, dma_rdata_o;
    logic [7:0]  cpu_be_i, sto_be_o, pio_be_o, dma_be_i, dsto_be_o, peer_be_o, b;
    logic [71:0] nx;
    logic [3:0]  lat;
    logic        wr;
    int          fails, n_checks;
    wire  [31:0] rd_addr = sto_valid_o ? sto_addr_o : (dsto_valid_o ? dsto_addr_o : pio_addr_o);

    bsw_swapper i_dut (.*);
    bsw_far_side i_far (.clk_i(clk_i), .reset_n_i(reset_n_i), .lat_i(lat), .sto_rd_i(sto_valid_o & ~sto_write_o),
        .dma_rd_i(dsto_valid_o & ~dsto_write_o), .pio_rd_i(pio_valid_o & ~pio_write_o), .addr_i(rd_addr),
        .sto_rvalid_o(sto_rvalid_i), .sto_rdma_o(sto_rdma_i), .sto_rdata_o(sto_rdata_i),
        .pio_rvalid_o(pio_rvalid_i), .pio_rdata_o(pio_rdata_i));

    // Free-running 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic close_out;
        if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [63:0] rev(input logic [63:0] x);
        for (int i = 0; i < 8; i++) rev[8*i +: 8] = x[56-8*i +: 8];
    endfunction : rev

    function automatic logic [7:0] rbe(input logic [7:0] x);
        for (int i = 0; i < 8; i++) rbe[i] = x[7-i];
    endfunction : rbe

    // Narrow word placement: data lanes in [71:8], byte enables in [7:0]
    function automatic logic [71:0] nar(input logic [31:0] w, input logic [3:0] e, input logic odd, input logic l);
        int n;
        nar = '0;
        for (int j = 0; j < 4; j++) begin
            n = l ? (odd ? 3 - j : 7 - j) : (odd ? 4 + j : j);
            nar[64-8*n +: 8] = w[24-8*j +: 8];
            nar[7-n] = e[3-j];
        end
    endfunction : nar

    function automatic logic [31:0] madr(input logic [31:0] x, input bsw_size_t s, input logic l);
        logic [2:0] m;
        m = (s == BSW_SZ_BYTE) ? 3'h7 : (s == BSW_SZ_HALF) ? 3'h6 : (s == BSW_SZ_WORD) ? 3'h4 : 3'h0;
        madr = l ? {x[31:3], x[2:0] ^ m} : x;
    endfunction : madr

    task automatic cpu_req(input logic io);
        @(posedge clk_i);
        {cpu_valid_i, cpu_to_io_i, cpu_write_i, cpu_size_i} <= {1'b1, io, wr, sz};
        {cpu_addr_i, cpu_wdata_i, cpu_be_i, cpu_cache_i} <= {a, d, b, 1'($urandom)};
        @(posedge clk_i);
        cpu_valid_i <= 1'b0;
        #1;
    endtask : cpu_req

    task automatic dma_req(input logic peer, input logic narrow);
        @(posedge clk_i);
        {dma_valid_i, dma_peer_i, dma_narrow_i, dma_write_i, dma_size_i} <= {1'b1, peer, narrow, wr, sz};
        {dma_addr_i, dma_wdata_i, dma_be_i} <= {a, d, b};
        @(posedge clk_i);
        dma_valid_i <= 1'b0;
        #1;
    endtask : dma_req

    task automatic wait_rv(input logic dma, input logic [63:0] exp);
        int k;
        for (k = 0; k < 40; k++) begin
            if ((dma ? dma_rvalid_o : cpu_rvalid_o) === 1'b1) break;
            @(posedge clk_i);
            #1;
        end
        if (k == 40) begin
            fails++;
            close_out();
        end else begin
            chk(dma ? dma_rdata_o : cpu_rdata_o, exp);
        end
    endtask : wait_rv

    initial begin
        {reset_n_i, mode_wr_i, mode_wdata_i, cpu_valid_i, cpu_write_i, cpu_to_io_i, cpu_cache_i} = '0;
        {dma_valid_i, dma_write_i, dma_peer_i, dma_narrow_i, cpu_addr_i, cpu_wdata_i, cpu_be_i} = '0;
        {dma_addr_i, dma_wdata_i, dma_be_i, lat, fails, n_checks} = '0;
        cpu_size_i = BSW_SZ_BYTE;
        dma_size_i = BSW_SZ_BYTE;
        void'($urandom(1));
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk(64'(mode_o), 64'(BSW_MODE_RST));
        for (int m = 0; m < 2; m++) begin
            // Mode is settled before any traffic is issued
            le = m[0];
            @(posedge clk_i);
            {mode_wr_i, mode_wdata_i} <= {1'b1, le};
            @(posedge clk_i);
            mode_wr_i <= 1'b0;
            #1;
            chk(64'(mode_o), 64'(le));
            repeat (30) begin
                sz = bsw_size_t'($urandom_range(3));
                a = $urandom;
                a[2:0] &= ~((3'h1 << sz) - 3'h1);
                d = {$urandom, $urandom};
                b = 8'($urandom);
                wr = 1'($urandom);
                lat = 4'($urandom_range(6));
                ea = madr(a, sz, le);
                cpu_req(1'b0);
                chk({sto_valid_o, sto_write_o, sto_addr_o}, {1'b1, wr, a});
                chk({sto_wdata_o}, d);
                chk({sto_be_o, sto_cache_o}, {b, cpu_cache_i});
                if (!wr) wait_rv(1'b0, {a, ~a});
                cpu_req(1'b1);
                chk({pio_valid_o, pio_write_o, pio_addr_o}, {1'b1, wr, ea});
                chk(pio_wdata_o, le ? rev(d) : d);
                chk(64'(pio_be_o), 64'(le ? rbe(b) : b));
                if (!wr) wait_rv(1'b0, le ? rev({ea, ~ea}) : {ea, ~ea});
                dma_req(1'b0, 1'b0);
                chk({dsto_valid_o, dsto_write_o, dma_split_err_o, dsto_addr_o}, {2'b11 & {1'b1, wr}, 1'b0, ea});
                chk(dsto_wdata_o, le ? rev(d) : d);
                chk(64'(dsto_be_o), 64'(le ? rbe(b) : b));
                if (!wr) wait_rv(1'b1, le ? rev({ea, ~ea}) : {ea, ~ea});
                a = $urandom;
                dma_req(1'b1, 1'b0);
                chk({peer_valid_o, peer_write_o, dsto_valid_o, peer_addr_o}, {1'b1, wr, 1'b0, a});
                chk(peer_wdata_o ^ 64'(peer_be_o), d ^ 64'(b));
                wr = 1'b1;
                sz = BSW_SZ_WORD;
                a[1:0] = 2'h0;
                nx = nar(d[31:0], b[3:0], a[2], le);
                ea = madr(a, sz, le);
                dma_req(1'b0, 1'b1);
                chk({dsto_valid_o, dsto_addr_o}, {1'b1, ea});
                chk(dsto_wdata_o, nx[71:8]);
                chk(64'(dsto_be_o), 64'(nx[7:0]));
                // Narrow read: its word comes back in the low half, upper half zero
                wr = 1'b0;
                dma_req(1'b0, 1'b1);
                d = le ? rev({ea, ~ea}) : {ea, ~ea};
                wait_rv(1'b1, 64'(a[2] ? d[31:0] : d[63:32]));
                wr = 1'b1;
                sz = bsw_size_t'(1 + $urandom_range(2));
                a[2:0] = 3'h7;
                dma_req(1'b0, 1'b0);
                chk({dma_split_err_o, dsto_valid_o}, 2'b10);
                sz = BSW_SZ_HALF;
                a[2:0] = 3'h1;
                dma_req(1'b0, 1'b0);
                chk({dma_split_err_o, dsto_valid_o}, {le, ~le});
            end
        end
        close_out();
    end
endmodule : tb_bi_endian_io_storage_swapper
`default_nettype wire
